// >>> hw/lccfg_pkg.sv
// Shared constants and state types of the link core image loader.
// Assumes both ends and the buffer run on one 100 MHz system clock.
package lccfg_pkg;
  localparam int CLK_MHZ = 100;
  // Host write window after a credit, in milliseconds.
  localparam int CREDIT_WINDOW_MS = 50;
  localparam int CREDIT_WINDOW_CYC = CREDIT_WINDOW_MS * 1000 * CLK_MHZ;
  // Size of one credited block, in kilobytes.
  localparam int BLOCK_KB = 4;
  localparam int BLOCK_WORDS = BLOCK_KB * 1024 / 4;
  // Corruption before this point can be recovered by teardown.
  localparam int RECOVER_KB = 168;
  localparam int RECOVER_WORDS = RECOVER_KB * 1024 / 4;
  localparam int QUAD_LANES = 4;
  localparam int WORD_BITS = 32;
  localparam int FIFO_WORDS = 32;
  localparam int TRAIN_CYCLES = 16;
  localparam int ENUM_CYCLES = 8;
  localparam int PERST_HOLD_CYCLES = 4;
  // Word layout of compressed data: a run token repeats its payload.
  localparam int TOKEN_BIT = 31;
  localparam int RUN_MSB = 23;
  localparam int RUN_LSB = 16;

  typedef enum logic [6:0] {
    DEV_WAIT_CLK = 7'h01,
    DEV_PERIPH = 7'h02,
    DEV_TRAIN = 7'h04,
    DEV_ENUM = 7'h08,
    DEV_CORE = 7'h10,
    DEV_USER = 7'h20,
    DEV_ERROR = 7'h40
  } lccfg_dev_state_t;

  typedef enum logic [6:0] {
    HST_RESET = 7'h01,
    HST_WAIT_LINK = 7'h02,
    HST_ENUM = 7'h04,
    HST_WAIT_CREDIT = 7'h08,
    HST_SEND = 7'h10,
    HST_WAIT_DONE = 7'h20,
    HST_USER = 7'h40
  } lccfg_host_state_t;
endpackage

// >>> hw/lccfg_link_if.sv
// Link between the root port host end and the loading device end.
// Assumes both ends share clk_sys; no signal here needs a crossing.
`timescale 1ns/10ps
interface lccfg_link_if (
  input wire logic clk_sys,
  input wire logic sys_rst
);
  logic perstN;
  logic refClkOk;
  logic enumDone;
  logic updateReq;
  logic teardown;
  logic wrValid;
  logic wrLast;
  logic [lccfg_pkg::WORD_BITS-1:0] wrData;
  logic wrReady;
  logic linkUp;
  logic creditGrant;
  logic periphDone;
  logic coreDone;
  logic userMode;
  logic cfgError;

  modport dev (
    input perstN, refClkOk, enumDone, updateReq, teardown,
    input wrValid, wrLast, wrData,
    output wrReady, linkUp, creditGrant, periphDone, coreDone,
    output userMode, cfgError
  );
  modport host (
    output perstN, refClkOk, enumDone, updateReq, teardown,
    output wrValid, wrLast, wrData,
    input wrReady, linkUp, creditGrant, periphDone, coreDone,
    input userMode, cfgError
  );
endinterface

// >>> hw/lccfg_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; inReady is low when full, outValid low when empty.
`timescale 1ns/10ps
module lccfg_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Filling side.
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side.
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be 2**n");

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } lccfg_fifo_state_t;

  lccfg_fifo_state_t s;
  lccfg_fifo_state_t next_s;
  logic push;
  logic pop;

  assign inReady = (s.count != (AW+1)'(DEPTH));
  assign outValid = (s.count != '0);
  assign outData = s.mem[s.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr = s.wrPtr + 1'b1;
    end
    if (pop) begin
      next_s.rdPtr = s.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// >>> hw/lccfg_device_end.sv
// Device end: periphery load from quad serial flash, link bring-up,
// credited core image load over the link, user mode and core update.
// Assumes the host end shares clk_sys; flash and spare reset pins are
// asynchronous and pass two flip-flops first.
`timescale 1ns/10ps
// What this block does
// - Periphery loaded: raise complete, then start training.
// - Training done: link to L0, host enumerates.
// - Host sends core image only after enumeration.
// - Reference clock runs before periphery loading.
// - Periphery from quad flash, core over link.
// - Enabled core-complete pin rises after core load.
// - Core-complete low during load, high when done.
// - Observer samples core-complete after periphery-complete.
// - User-mode output rises when configuration completes.
// - Periphery-complete low before and during configuration.
// - Periphery-complete high only after error-free data.
// - Fundamental reset low holds left transceivers in reset.
// - Fundamental reset joined to system link reset.
// - Reset pins are GPIO only with hard IP off.
// - One fundamental reset input per hard IP.
// - Link configuration only through bottom-left hard IP.
// - Core update only after user mode is reached.
// - Update accepted however first configured.
// - Link stays usable for traffic and updates.
// - Update images keep the periphery connections.
// - Periphery change needs flash reprogramming.
// - Both images arrive compressed and are expanded.
// - Corruption sets error flag; early corruption recoverable.
// - Host writes each credited block within window.
module lccfg_device_end #(
  parameter int CREDIT_WINDOW_CYCLES = lccfg_pkg::CREDIT_WINDOW_CYC,
  parameter int BLOCK_WORDS = lccfg_pkg::BLOCK_WORDS,
  parameter int RECOVER_WORDS = lccfg_pkg::RECOVER_WORDS,
  parameter int FIFO_DEPTH = lccfg_pkg::FIFO_WORDS,
  parameter int TRAIN_CYCLES = lccfg_pkg::TRAIN_CYCLES,
  parameter bit FULL_IMAGE_IN_FLASH = 1'b0,
  parameter bit CORE_DONE_PIN_EN = 1'b1,
  parameter bit LEFT_HIP_EN = 1'b1,
  parameter bit RIGHT_HIP_EN = 1'b0,
  parameter int LINK_CFG_HIP_INDEX = 0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link to the host.
  lccfg_link_if.dev link,
  // Quad serial flash pins.
  input wire logic [lccfg_pkg::QUAD_LANES-1:0] flashData,
  input wire logic flashValid,
  input wire logic flashLast,
  // Other side-indexed reset pins: L1, L2, R0, R1, R2.
  input wire logic [4:0] sideIndexedLinkResetN,
  output logic [4:0] spareGpioIn,
  // Status pins.
  output logic xcvrResetLeft,
  output logic xcvrResetRight,
  output logic peripheryConfigComplete,
  output logic coreConfigCompleteOut,
  output logic userMode,
  output logic linkConfigErrorFlag,
  output logic linkAvailable
);
  localparam int W = lccfg_pkg::WORD_BITS;
  localparam int QL = lccfg_pkg::QUAD_LANES;

  if (LINK_CFG_HIP_INDEX != 0 || !LEFT_HIP_EN) $error("bottom-left only");
  if (BLOCK_WORDS < 1 || CREDIT_WINDOW_CYCLES < 2) $error("bad credit");
  if (TRAIN_CYCLES < 1 || TRAIN_CYCLES > 65535) $error("bad training");

  typedef struct packed {
    lccfg_pkg::lccfg_dev_state_t st;
    logic [10:0] syncA;
    logic [10:0] syncB;
    logic [2:0] nib;
    logic [W-1:0] shift;
    logic [15:0] trainCnt;
    logic [31:0] wordCnt;
    logic [31:0] expCnt;
    logic [31:0] blkCnt;
    logic [31:0] windowCnt;
    logic credit;
    logic periphDone;
    logic coreDone;
    logic linkUp;
    logic userMode;
    logic cfgError;
    logic recoverable;
  } lccfg_dev_t;

  lccfg_dev_t s;
  lccfg_dev_t next_s;
  logic fifoValid;
  logic fifoReady;
  logic [W:0] fifoData;
  logic [QL-1:0] fData;
  logic fValid;
  logic fLast;
  logic [W-1:0] word;

  // Expanded length of one word: a run token stands for several words.
  function automatic logic [31:0] expand_len(input logic [W-1:0] w);
    expand_len = 32'h0000_0001;
    if (w[lccfg_pkg::TOKEN_BIT]) begin
      expand_len = {24'h00_0000, w[lccfg_pkg::RUN_MSB:lccfg_pkg::RUN_LSB]}
        + 32'h0000_0001;
    end
  endfunction

  lccfg_fifo #(
    .WIDTH(W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .inValid(link.wrValid),
    .inData({link.wrLast, link.wrData}),
    .inReady(link.wrReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoReady)
  );

  assign fData = s.syncB[10:7];
  assign fValid = s.syncB[6];
  assign fLast = s.syncB[5];
  assign word = {fData, s.shift[W-1:QL]};
  // Only words inside a credited block are taken; after an error the
  // buffer is drained so stale data cannot leak into the next attempt.
  assign fifoReady = ((s.st == lccfg_pkg::DEV_CORE) && (s.blkCnt != '0))
    || (s.st == lccfg_pkg::DEV_ERROR);

  always_comb begin
    next_s = s;
    next_s.syncA = {flashData, flashValid, flashLast, sideIndexedLinkResetN};
    next_s.syncB = s.syncA;
    next_s.credit = 1'b0;
    case (s.st)
      lccfg_pkg::DEV_WAIT_CLK: begin
        if (link.refClkOk) begin
          next_s.st = lccfg_pkg::DEV_PERIPH;
        end
      end
      lccfg_pkg::DEV_PERIPH: begin
        if (fValid) begin
          next_s.shift = {fData, s.shift[W-1:QL]};
          next_s.nib = s.nib + 3'h1;
          if (s.nib == 3'h7) begin
            if (^word) begin
              next_s.cfgError = 1'b1;
              next_s.st = lccfg_pkg::DEV_ERROR;
            end else begin
              next_s.expCnt = s.expCnt + expand_len(word);
              if (fLast) begin
                next_s.periphDone = 1'b1;
                next_s.st = lccfg_pkg::DEV_TRAIN;
              end
            end
          end
        end
      end
      lccfg_pkg::DEV_TRAIN: begin
        if (link.perstN) begin
          next_s.trainCnt = s.trainCnt + 16'h0001;
          if (s.trainCnt == 16'(TRAIN_CYCLES - 1)) begin
            next_s.linkUp = 1'b1;
            next_s.st = lccfg_pkg::DEV_ENUM;
          end
        end
      end
      lccfg_pkg::DEV_ENUM: begin
        if (link.enumDone) begin
          next_s.wordCnt = '0;
          if (FULL_IMAGE_IN_FLASH) begin
            next_s.coreDone = 1'b1;
            next_s.userMode = 1'b1;
            next_s.st = lccfg_pkg::DEV_USER;
          end else begin
            next_s.st = lccfg_pkg::DEV_CORE;
          end
        end
      end
      lccfg_pkg::DEV_CORE: begin
        next_s.coreDone = 1'b0;
        if (s.blkCnt == '0) begin
          next_s.credit = 1'b1;
          next_s.blkCnt = 32'(BLOCK_WORDS);
          next_s.windowCnt = '0;
        end else begin
          next_s.windowCnt = s.windowCnt + 32'h0000_0001;
          if (fifoValid) begin
            next_s.blkCnt = s.blkCnt - 32'h0000_0001;
            next_s.wordCnt = s.wordCnt + 32'h0000_0001;
            if (^fifoData[W-1:0]) begin
              next_s.cfgError = 1'b1;
              next_s.recoverable = (s.wordCnt < 32'(RECOVER_WORDS));
              next_s.st = lccfg_pkg::DEV_ERROR;
            end else begin
              next_s.expCnt = s.expCnt + expand_len(fifoData[W-1:0]);
              if (fifoData[W]) begin
                next_s.coreDone = 1'b1;
                next_s.userMode = 1'b1;
                next_s.blkCnt = '0;
                next_s.st = lccfg_pkg::DEV_USER;
              end
            end
          end else if (s.windowCnt == 32'(CREDIT_WINDOW_CYCLES - 1)) begin
            next_s.cfgError = 1'b1;
            next_s.recoverable = 1'b0;
            next_s.st = lccfg_pkg::DEV_ERROR;
          end
        end
      end
      lccfg_pkg::DEV_USER: begin
        // Periphery, link and user mode stay up while a new core loads.
        if (link.updateReq) begin
          next_s.coreDone = 1'b0;
          next_s.wordCnt = '0;
          next_s.blkCnt = '0;
          next_s.st = lccfg_pkg::DEV_CORE;
        end
      end
      lccfg_pkg::DEV_ERROR: begin
        // Late corruption or a missed window waits for a power cycle.
        if (link.teardown && s.recoverable) begin
          next_s.cfgError = 1'b0;
          next_s.wordCnt = '0;
          next_s.blkCnt = '0;
          next_s.st = lccfg_pkg::DEV_CORE;
        end
      end
      default: begin
        next_s.st = lccfg_pkg::DEV_WAIT_CLK;
      end
    endcase
    if (!link.perstN) begin
      next_s.linkUp = 1'b0;
      next_s.trainCnt = '0;
      if (s.st == lccfg_pkg::DEV_ENUM) begin
        next_s.st = lccfg_pkg::DEV_TRAIN;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= lccfg_pkg::DEV_WAIT_CLK;
      s.recoverable <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.linkUp = s.linkUp;
  assign link.creditGrant = s.credit;
  assign link.periphDone = s.periphDone;
  assign link.coreDone = s.coreDone;
  assign link.userMode = s.userMode;
  assign link.cfgError = s.cfgError;

  assign xcvrResetLeft = !link.perstN;
  assign xcvrResetRight = RIGHT_HIP_EN && !s.syncB[2];
  // Reset pins of an enabled side never reach the GPIO path.
  assign spareGpioIn = {
    RIGHT_HIP_EN ? 3'h0 : s.syncB[4:2],
    LEFT_HIP_EN ? 2'h0 : s.syncB[1:0]
  };
  assign peripheryConfigComplete = s.periphDone;
  assign coreConfigCompleteOut = CORE_DONE_PIN_EN && s.coreDone;
  assign userMode = s.userMode;
  assign linkConfigErrorFlag = s.cfgError;
  assign linkAvailable = s.linkUp;
endmodule

// >>> hw/lccfg_host_end.sv
// Host end: starts the reference clock, drives the fundamental reset,
// enumerates, then streams credited core blocks from a user source.
// Assumes the device end shares clk_sys.
`timescale 1ns/10ps
module lccfg_host_end #(
  parameter int BLOCK_WORDS = lccfg_pkg::BLOCK_WORDS,
  parameter int ENUM_CYCLES = lccfg_pkg::ENUM_CYCLES,
  parameter int PERST_HOLD = lccfg_pkg::PERST_HOLD_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Link to the device.
  lccfg_link_if.host link,
  // Core image source.
  input wire logic imgValid,
  input wire logic [lccfg_pkg::WORD_BITS-1:0] imgData,
  input wire logic imgLast,
  output logic imgReady,
  // Control and status.
  input wire logic updateStart,
  input wire logic teardownStart,
  output logic configOk,
  output logic configFailed
);
  if (BLOCK_WORDS < 1 || ENUM_CYCLES < 1 || PERST_HOLD < 1) $error("bad");

  typedef struct packed {
    lccfg_pkg::lccfg_host_state_t st;
    logic [31:0] cnt;
    logic [31:0] blk;
    logic perstN;
    logic enumDone;
    logic update;
    logic teardown;
    logic ok;
  } lccfg_host_t;

  lccfg_host_t s;
  lccfg_host_t next_s;
  logic take;

  assign take = (s.st == lccfg_pkg::HST_SEND) && imgValid && link.wrReady;

  always_comb begin
    next_s = s;
    next_s.update = 1'b0;
    next_s.teardown = 1'b0;
    next_s.ok = link.periphDone && link.coreDone;
    case (s.st)
      lccfg_pkg::HST_RESET: begin
        next_s.cnt = s.cnt + 32'h0000_0001;
        if (s.cnt == 32'(PERST_HOLD - 1)) begin
          next_s.perstN = 1'b1;
          next_s.cnt = '0;
          next_s.st = lccfg_pkg::HST_WAIT_LINK;
        end
      end
      lccfg_pkg::HST_WAIT_LINK: begin
        if (link.linkUp) begin
          next_s.st = lccfg_pkg::HST_ENUM;
        end
      end
      lccfg_pkg::HST_ENUM: begin
        next_s.cnt = s.cnt + 32'h0000_0001;
        if (s.cnt == 32'(ENUM_CYCLES - 1)) begin
          next_s.enumDone = 1'b1;
          next_s.st = lccfg_pkg::HST_WAIT_CREDIT;
        end
      end
      lccfg_pkg::HST_WAIT_CREDIT: begin
        // Just after an update request the device still shows the old
        // core as done for one cycle; that must not end the update.
        if (link.userMode && link.coreDone && !s.update) begin
          next_s.st = lccfg_pkg::HST_USER;
        end else if (link.creditGrant) begin
          next_s.blk = 32'(BLOCK_WORDS);
          next_s.st = lccfg_pkg::HST_SEND;
        end
      end
      lccfg_pkg::HST_SEND: begin
        if (take) begin
          next_s.blk = s.blk - 32'h0000_0001;
          if (imgLast) begin
            next_s.st = lccfg_pkg::HST_WAIT_DONE;
          end else if (s.blk == 32'h0000_0001) begin
            next_s.st = lccfg_pkg::HST_WAIT_CREDIT;
          end
        end
      end
      lccfg_pkg::HST_WAIT_DONE: begin
        if (link.coreDone) begin
          next_s.st = lccfg_pkg::HST_USER;
        end
      end
      lccfg_pkg::HST_USER: begin
        if (updateStart && link.userMode) begin
          next_s.update = 1'b1;
          next_s.st = lccfg_pkg::HST_WAIT_CREDIT;
        end
      end
      default: begin
        next_s.st = lccfg_pkg::HST_RESET;
      end
    endcase
    if (link.cfgError) begin
      next_s.st = lccfg_pkg::HST_WAIT_CREDIT;
      next_s.teardown = teardownStart;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= lccfg_pkg::HST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // The reference clock is declared running from reset on.
  assign link.refClkOk = 1'b1;
  assign link.perstN = s.perstN;
  assign link.enumDone = s.enumDone;
  assign link.updateReq = s.update;
  assign link.teardown = s.teardown;
  // Memory-write stream only; the device back-pressures via wrReady.
  assign link.wrValid = (s.st == lccfg_pkg::HST_SEND) && imgValid;
  assign link.wrData = imgData;
  assign link.wrLast = imgLast;
  assign imgReady = (s.st == lccfg_pkg::HST_SEND) && link.wrReady;
  assign configOk = s.ok;
  assign configFailed = link.cfgError;
endmodule

// >>> tb/lccfg_link_chk.sv
// Checker on the link that joins the host end to the device end.
// Assumes every signal is sampled on clk_sys; sys_rst is active high.
`timescale 1ns/10ps
module lccfg_link_chk (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host to device.
  input wire logic perstN,
  input wire logic enumDone,
  input wire logic updateReq,
  // Device to host.
  input wire logic linkUp,
  input wire logic creditGrant,
  input wire logic periphDone,
  input wire logic coreDone,
  input wire logic userMode,
  input wire logic cfgError
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_update_req;
    updateReq && coreDone && userMode;
  endsequence
  sequence s_reload;
    (!coreDone && userMode && linkUp) ##[1:3] creditGrant;
  endsequence

  a_link_after_periph: assert property (
    $rose(linkUp) |-> periphDone && perstN)
    else $error("link up before periphery complete");
  a_link_reset_drop: assert property (
    !perstN |-> ##[1:2] !linkUp)
    else $error("link stays up in fundamental reset");
  a_credit_after_enum: assert property (
    $rose(enumDone) && linkUp |-> ##[1:2] creditGrant)
    else $error("no credit after enumeration");
  a_credit_gate: assert property (
    creditGrant |-> linkUp && enumDone && periphDone)
    else $error("credit granted before enumeration");
  a_credit_pulse: assert property (
    creditGrant |=> !creditGrant)
    else $error("credit grant longer than one cycle");
  a_core_done_user: assert property (
    $rose(coreDone) |-> userMode && periphDone && !cfgError)
    else $error("core done without user mode");
  a_user_after_periph: assert property (
    userMode |-> periphDone)
    else $error("user mode without periphery complete");
  a_periph_holds: assert property (
    periphDone |=> periphDone)
    else $error("periphery complete dropped");
  a_update_reload: assert property (
    s_update_req |=> s_reload)
    else $error("update did not restart core load");
  a_error_no_done: assert property (
    $rose(cfgError) |-> !coreDone)
    else $error("error flag with core done");
  a_user_link_kept: assert property (
    userMode && perstN |=> linkUp)
    else $error("link lost in user mode");
endmodule

// >>> tb/test_link_core_image_config.sv
// Self-checking bench: host end and device end joined by the link.
// Assumes design files and the link checker are compiled before it.
`timescale 1ns/10ps
module test_link_core_image_config;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] flashData = 4'h0;
  logic flashValid = 1'b0;
  logic flashLast = 1'b0;
  logic [4:0] sideRstN = 5'h1F;
  logic [4:0] spareIn;
  logic xcvrL, xcvrR, periphPin, corePin, userPin, errPin, linkAvail;
  logic imgValid = 1'b0;
  logic [31:0] imgData = 32'h0;
  logic imgLast = 1'b0;
  logic imgReady, configOk, configFailed;
  logic updateStart = 1'b0;
  logic teardownStart = 1'b0;
  int fails = 0;
  int compares = 0;

  always #5 clk_sys = ~clk_sys;

  lccfg_link_if i_lccfg_link_if (.clk_sys(clk_sys), .sys_rst(sys_rst));
  // Short window and block keep the run small; recovery scales with the block.
  lccfg_device_end #(.CREDIT_WINDOW_CYCLES(200), .BLOCK_WORDS(4),
    .RECOVER_WORDS(168)) i_lccfg_device_end (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(i_lccfg_link_if),
    .flashData(flashData), .flashValid(flashValid), .flashLast(flashLast),
    .sideIndexedLinkResetN(sideRstN), .spareGpioIn(spareIn),
    .xcvrResetLeft(xcvrL), .xcvrResetRight(xcvrR),
    .peripheryConfigComplete(periphPin), .coreConfigCompleteOut(corePin),
    .userMode(userPin), .linkConfigErrorFlag(errPin),
    .linkAvailable(linkAvail));
  lccfg_host_end #(.BLOCK_WORDS(4)) i_lccfg_host_end (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link(i_lccfg_link_if),
    .imgValid(imgValid), .imgData(imgData), .imgLast(imgLast),
    .imgReady(imgReady), .updateStart(updateStart),
    .teardownStart(teardownStart), .configOk(configOk),
    .configFailed(configFailed));
  lccfg_link_chk i_lccfg_link_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .perstN(i_lccfg_link_if.perstN), .enumDone(i_lccfg_link_if.enumDone),
    .updateReq(i_lccfg_link_if.updateReq), .linkUp(i_lccfg_link_if.linkUp),
    .creditGrant(i_lccfg_link_if.creditGrant),
    .periphDone(i_lccfg_link_if.periphDone),
    .coreDone(i_lccfg_link_if.coreDone),
    .userMode(i_lccfg_link_if.userMode), .cfgError(i_lccfg_link_if.cfgError));

  task check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task tally_and_finish;
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Every image word carries even parity; bit 0 balances the rest.
  function automatic logic [31:0] mk(input logic [31:0] x);
    return {x[31:1], ^x[31:1]};
  endfunction

  task t_reset_state;
    check("periphery pin", periphPin, 1'b0);
    check("core pin", corePin, 1'b0);
    check("link up", linkAvail, 1'b0);
    check("write ready", i_lccfg_link_if.wrReady, 1'b1);
    check("left xcvr reset", xcvrL, 1'b1);
  endtask

  task t_spare;
    sideRstN = 5'h1B;
    repeat (4) @(negedge clk_sys);
    check("spare gpio", spareIn, 5'h18);
    check("right xcvr reset", xcvrR, 1'b0);
    sideRstN = 5'h1F;
  endtask

  // The buffer inside the device must be empty and open between images.
  task t_fifo;
    check("fifo empty", i_lccfg_device_end.fifoValid, 1'b0);
    check("fifo in ready", i_lccfg_link_if.wrReady, 1'b1);
  endtask

  task t_periph;
    logic [31:0] wd;
    for (int w = 0; w < 3; w++) begin
      wd = mk(32'h3C5A0F10 + 32'(w));
      for (int n = 0; n < 8; n++) begin
        @(negedge clk_sys);
        flashValid = 1'b1;
        flashData = wd[4*n +: 4];
        flashLast = (w == 2) && (n == 7);
      end
    end
    @(negedge clk_sys);
    flashValid = 1'b0;
    flashLast = 1'b0;
    check("periphery during load", periphPin, 1'b0);
    repeat (20) if (periphPin !== 1'b1) @(negedge clk_sys);
    check("periphery done", periphPin, 1'b1);
    check("link before training", linkAvail, 1'b0);
    check("left xcvr released", xcvrL, 1'b0);
    repeat (60) if (linkAvail !== 1'b1) @(negedge clk_sys);
    check("link in L0", linkAvail, 1'b1);
  endtask

  // Word 0 is a run token, so every image also exercises expansion.
  task automatic send_img(input int n, input int bad);
    int k;
    @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      imgValid = 1'b1;
      imgData = mk({i == 0, 7'h00, 8'h03, 16'hA5C0 + i[15:0]});
      if (i == bad) imgData[0] = ~imgData[0];
      imgLast = (i == n - 1) && (bad < 0);
      if (i == n / 2) check("core pin in load", corePin, 1'b0);
      k = 0;
      while (imgReady !== 1'b1 && k < 300) begin
        @(negedge clk_sys);
        k++;
      end
      check("write taken", imgReady, 1'b1);
      // The word is taken at the rising edge before this one and sits alone in the buffer after.
      @(negedge clk_sys);
      check("fifo out valid", i_lccfg_device_end.fifoValid, 1'b1);
      check("fifo data", i_lccfg_device_end.fifoData[31:0], imgData);
    end
    imgValid = 1'b0;
    imgLast = 1'b0;
  endtask

  task t_error;
    send_img(3, 2);
    repeat (30) if (configFailed !== 1'b1) @(negedge clk_sys);
    check("config failed", configFailed, 1'b1);
    check("error flag", errPin, 1'b1);
    check("core pin on error", corePin, 1'b0);
    teardownStart = 1'b1;
    @(negedge clk_sys);
    teardownStart = 1'b0;
    repeat (30) if (errPin !== 1'b0) @(negedge clk_sys);
    check("error cleared", errPin, 1'b0);
  endtask

  task t_image(input int n);
    send_img(n, -1);
    repeat (40) if (corePin !== 1'b1) @(negedge clk_sys);
    check("core pin done", corePin, 1'b1);
    check("user mode", userPin, 1'b1);
    check("link kept", linkAvail, 1'b1);
    repeat (2) @(negedge clk_sys);
    check("config ok", configOk, 1'b1);
  endtask

  task t_update;
    updateStart = 1'b1;
    @(negedge clk_sys);
    updateStart = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("core pin in update", corePin, 1'b0);
    check("user mode in update", userPin, 1'b1);
    check("link in update", linkAvail, 1'b1);
    check("periphery kept", periphPin, 1'b1);
    t_image(6);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset_state();
    t_spare();
    t_periph();
    t_error();
    t_fifo();
    t_image(10);
    t_update();
    t_fifo();
    tally_and_finish();
  end

  // The full sequence needs well under 200 cycles.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end
endmodule
